// ---- pkg/gpsc_pkg.sv ----
// Purpose: Shared constants and types for the eight-pin set/clear/sense port
// Assumes: Byte-wide register port, one clock, asynchronous active-high reset
// Notes:   Offsets are byte addresses on the plain register port
`default_nettype none
package gpsc_pkg;
    localparam int unsigned PINS = 8;
    localparam int unsigned AW   = 5;

    // Register offsets
    localparam logic [4:0] OFF_DIRECTION = 5'h00;
    localparam logic [4:0] OFF_LEVEL     = 5'h04;
    localparam logic [4:0] OFF_SET       = 5'h05;
    localparam logic [4:0] OFF_CLEAR     = 5'h06;
    localparam logic [4:0] OFF_TOGGLE    = 5'h07;
    localparam logic [4:0] OFF_INPUT     = 5'h08;
    localparam logic [4:0] OFF_FLAGS     = 5'h09;
    localparam logic [4:0] OFF_PORTCTL   = 5'h0a;
    localparam logic [4:0] OFF_MASK      = 5'h0b;
    localparam logic [4:0] OFF_PINCFG    = 5'h10;

    // Field positions
    localparam int unsigned POS_SLEW   = 0;
    localparam int unsigned POS_INVERT = 7;
    localparam int unsigned POS_PULL   = 3;

    // Reset value and per-pin config write mask
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CFG_MASK = 8'h8f;

    typedef enum logic [2:0] {
        SENSE_NONE    = 3'h0,
        SENSE_BOTH    = 3'h1,
        SENSE_RISE    = 3'h2,
        SENSE_FALL    = 3'h3,
        SENSE_OFF     = 3'h4,
        SENSE_LOW     = 3'h5
    } gpsc_sense_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } gpsc_bus_t;

    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en_n;
        logic [7:0] pull_en;
        logic       slew;
    } gpsc_pins_t;
endpackage : gpsc_pkg
`default_nettype wire

// ---- src/gpsc_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement of stages two and three
// Assumes: Pins are asynchronous to clock
// Notes:   Stage one feeds only stage two
`default_nettype none
module gpsc_sync #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // Data
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } gpsc_sync_t;

    gpsc_sync_t st_r;
    gpsc_sync_t st_nxt;

    // A zero-width bank has nothing to synchronise
    if (W < 1) begin : g_bad_width
        $error("gpsc_sync width must be at least one");
    end

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < int'(W); i++) begin
            // Accept a change only once two late stages agree
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_out = st_r.q;
endmodule : gpsc_sync
`default_nettype wire

// ---- src/gpsc_port.sv ----
// Purpose: Eight-pin GPIO port with set/clear/toggle strobes, input sense, flags
// Assumes: Byte register port, read data one cycle after the read strobe
// Notes:   Pins are driven from flip-flops; pin input passes gpsc_sync
//
// Contract
// - Writing set register sets output-level bits where written ones stand
// - Writing clear register clears output-level bits where written ones stand
// - Ones written to toggle or input-value register invert output-level bits
// - Strobes need no read-modify-write; zero bits change nothing
// - Reading set, clear or toggle returns the output-level register
// - Input-value bit follows sampled pin level while input buffer enabled
// - Disabled input buffer freezes the input-value bit
// - Pin event flag sets when pin matches its selected sense
// - Writing one clears a flag; zero leaves it
// - Port control bit zero enables slew limiting for all pins
// - Per-pin bit 7 inverts both driven and read values
// - Per-pin bit 3 enables pull-up, only while pin is input-only
// - Sense field: none, both, rise, fall, buffer off, low level
// - Output level drives the pin only while its direction bit is one
//
// Our own choice: the strobed register port.
`default_nettype none
module gpsc_port (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                reset,
    // Register port
    input  wire gpsc_pkg::gpsc_bus_t bus,
    output var  logic [7:0]          rdata,
    // Pins
    input  wire logic [7:0]          pin_in,
    output var  gpsc_pkg::gpsc_pins_t pins,
    // Interrupt
    output var  logic                irq
);
    typedef struct packed {
        logic [7:0]      dir;
        logic [7:0]      level;
        logic [7:0]      in_val;
        logic [7:0]      flags;
        logic [7:0]      mask;
        logic            slew;
        logic [7:0][7:0] cfg;
        logic [7:0]      prev;
        logic [7:0]      rdata;
        gpsc_pkg::gpsc_pins_t pins;
        logic            irq;
    } gpsc_state_t;

    gpsc_state_t st_r;
    gpsc_state_t st_nxt;
    logic [7:0]  pin_sync;
    logic [7:0]  pin_log;
    logic [7:0]  match;
    logic [7:0]  wr_flags;

    gpsc_sync #(.W(gpsc_pkg::PINS)) u_sync (
        .clock (clock),
        .reset (reset),
        .d_in  (pin_in),
        .q_out (pin_sync)
    );

    // Per-pin inversion and sense decode
    for (genvar g = 0; g < 8; g++) begin : g_pin
        gpsc_pkg::gpsc_sense_t sense;
        assign sense      = gpsc_pkg::gpsc_sense_t'(st_r.cfg[g][2:0]);
        assign pin_log[g] = pin_sync[g] ^ st_r.cfg[g][gpsc_pkg::POS_INVERT];
        always_comb begin
            case (sense)
                gpsc_pkg::SENSE_BOTH: match[g] = pin_log[g] != st_r.prev[g];
                gpsc_pkg::SENSE_RISE: match[g] = pin_log[g] & ~st_r.prev[g];
                gpsc_pkg::SENSE_FALL: match[g] = ~pin_log[g] & st_r.prev[g];
                gpsc_pkg::SENSE_LOW:  match[g] = ~pin_log[g];
                default:              match[g] = 1'b0;
            endcase
        end
    end

    assign wr_flags = (bus.wr && bus.addr == gpsc_pkg::OFF_FLAGS) ? bus.wdata : 8'h00;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = gpsc_pkg::RST_BYTE;
        // Input sampling, frozen when buffer disabled
        for (int i = 0; i < 8; i++) begin
            if (st_r.cfg[i][2:0] != 3'(gpsc_pkg::SENSE_OFF)) begin
                st_nxt.in_val[i] = pin_log[i];
                st_nxt.prev[i]   = pin_log[i];
            end
        end
        // Set beats clear
        st_nxt.flags = (st_r.flags & ~wr_flags) | match;
        if (bus.wr) begin
            case (bus.addr)
                gpsc_pkg::OFF_DIRECTION: st_nxt.dir   = bus.wdata;
                gpsc_pkg::OFF_LEVEL:     st_nxt.level = bus.wdata;
                gpsc_pkg::OFF_SET:       st_nxt.level = st_r.level | bus.wdata;
                gpsc_pkg::OFF_CLEAR:     st_nxt.level = st_r.level & ~bus.wdata;
                gpsc_pkg::OFF_TOGGLE,
                gpsc_pkg::OFF_INPUT:     st_nxt.level = st_r.level ^ bus.wdata;
                gpsc_pkg::OFF_PORTCTL:   st_nxt.slew  = bus.wdata[gpsc_pkg::POS_SLEW];
                gpsc_pkg::OFF_MASK:      st_nxt.mask  = bus.wdata;
                default: begin
                    if (bus.addr[4:3] == 2'b10) begin
                        st_nxt.cfg[bus.addr[2:0]] = bus.wdata & gpsc_pkg::CFG_MASK;
                    end
                end
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                gpsc_pkg::OFF_DIRECTION: st_nxt.rdata = st_r.dir;
                gpsc_pkg::OFF_LEVEL,
                gpsc_pkg::OFF_SET,
                gpsc_pkg::OFF_CLEAR,
                gpsc_pkg::OFF_TOGGLE:    st_nxt.rdata = st_r.level;
                gpsc_pkg::OFF_INPUT:     st_nxt.rdata = st_r.in_val;
                gpsc_pkg::OFF_FLAGS:     st_nxt.rdata = st_r.flags;
                gpsc_pkg::OFF_PORTCTL:   st_nxt.rdata = {7'h00, st_r.slew};
                gpsc_pkg::OFF_MASK:      st_nxt.rdata = st_r.mask;
                default: begin
                    if (bus.addr[4:3] == 2'b10) begin
                        st_nxt.rdata = st_r.cfg[bus.addr[2:0]];
                    end
                end
            endcase
        end
        // Pin drive from next state so pins change on the same edge as the register
        for (int i = 0; i < 8; i++) begin
            st_nxt.pins.out_val[i]  = st_nxt.level[i] ^ st_nxt.cfg[i][gpsc_pkg::POS_INVERT];
            st_nxt.pins.out_en_n[i] = ~st_nxt.dir[i];
            // Pull-up only useful with driver off
            st_nxt.pins.pull_en[i]  = st_nxt.cfg[i][gpsc_pkg::POS_PULL] & ~st_nxt.dir[i];
        end
        st_nxt.pins.slew = st_nxt.slew;
        st_nxt.irq       = |(st_nxt.flags & st_nxt.mask);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.pins.out_en_n <= 8'hff;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign pins  = st_r.pins;
    assign irq   = st_r.irq;

    a_set_strobe: assert property (@(posedge clock) disable iff (reset)
        bus.wr && bus.addr == gpsc_pkg::OFF_SET |=> (st_r.level & $past(bus.wdata)) == $past(bus.wdata))
        else $error("set strobe missed a bit");
    a_clear_strobe: assert property (@(posedge clock) disable iff (reset)
        bus.wr && bus.addr == gpsc_pkg::OFF_CLEAR |=> (st_r.level & $past(bus.wdata)) == 8'h00)
        else $error("clear strobe missed a bit");
    a_toggle_strobe: assert property (@(posedge clock) disable iff (reset)
        bus.wr && (bus.addr == gpsc_pkg::OFF_TOGGLE || bus.addr == gpsc_pkg::OFF_INPUT)
        |=> st_r.level == ($past(st_r.level) ^ $past(bus.wdata)))
        else $error("toggle wrong");
    a_strobe_read: assert property (@(posedge clock) disable iff (reset)
        bus.rd && bus.addr == gpsc_pkg::OFF_CLEAR && !bus.wr |=> rdata == $past(st_r.level))
        else $error("strobe read not level");
    a_input_frozen: assert property (@(posedge clock) disable iff (reset)
        st_r.cfg[0][2:0] == 3'h4 |=> st_r.in_val[0] == $past(st_r.in_val[0]))
        else $error("disabled input moved");
    a_flag_priority: assert property (@(posedge clock) disable iff (reset)
        match[0] |=> st_r.flags[0])
        else $error("flag set lost");
    a_flag_clear: assert property (@(posedge clock) disable iff (reset)
        wr_flags[1] && !match[1] |=> !st_r.flags[1])
        else $error("flag not cleared");
    a_drive_gate: assert property (@(posedge clock) disable iff (reset)
        !st_r.dir[2] |-> st_r.pins.out_en_n[2])
        else $error("driver on while input-only");
    a_pull_gate: assert property (@(posedge clock) disable iff (reset)
        st_r.dir[3] |-> !st_r.pins.pull_en[3])
        else $error("pull-up on while driving");
    a_irq_level: assert property (@(posedge clock) disable iff (reset)
        |(st_r.flags & st_r.mask) |-> irq)
        else $error("irq missing");
    a_zero_strobe: assert property (@(posedge clock) disable iff (reset)
        bus.wr && bus.wdata == 8'h00 && (bus.addr == gpsc_pkg::OFF_SET
        || bus.addr == gpsc_pkg::OFF_CLEAR || bus.addr == gpsc_pkg::OFF_TOGGLE)
        |=> st_r.level == $past(st_r.level))
        else $error("zero strobe moved the level");
    a_slew_follow: assert property (@(posedge clock) disable iff (reset)
        bus.wr && bus.addr == gpsc_pkg::OFF_PORTCTL |=> pins.slew == $past(bus.wdata[0]))
        else $error("slew enable not applied");
    a_input_follow: assert property (@(posedge clock) disable iff (reset)
        st_r.cfg[0][2:0] != 3'h4 |=> st_r.in_val[0] == $past(pin_log[0]))
        else $error("input value not sampled");
    a_invert_out: assert property (@(posedge clock) disable iff (reset)
        pins.out_val[0] == (st_r.level[0] ^ st_r.cfg[0][7]))
        else $error("driven value not inverted");
    a_rise_sense: assert property (@(posedge clock) disable iff (reset)
        st_r.cfg[0][2:0] == 3'h2 && pin_log[0] && !st_r.prev[0] |=> st_r.flags[0])
        else $error("rising edge not flagged");
    a_quiet_sense: assert property (@(posedge clock) disable iff (reset)
        st_r.cfg[0][2:0] == 3'h0 && !st_r.flags[0] |=> !st_r.flags[0])
        else $error("flag set with sense off");
    a_read_idle: assert property (@(posedge clock) disable iff (reset)
        !bus.rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule : gpsc_port
`default_nettype wire

// ---- verification/gpsc_board.sv ----
// Purpose: Board-side model of the eight port pins
// Assumes: Board drivers yield to the port driver
// Notes:   A floating pin flips each cycle so no stale level is trusted
`default_nettype none
module gpsc_board (
    // Clock
    input  wire logic                 clock,
    // Port pins and board drivers
    input  wire gpsc_pkg::gpsc_pins_t pins,
    input  wire logic [7:0]           ext_val,
    input  wire logic [7:0]           ext_en,
    // Level at the pins
    output var  logic [7:0]           pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_in = 8'h00;
    always @(posedge clock) begin
        for (int i = 0; i < 8; i++) begin
            if (!pins.out_en_n[i]) begin
                pin_in[i] <= pins.out_val[i];
            end else if (ext_en[i]) begin
                pin_in[i] <= ext_val[i];
            end else begin
                pin_in[i] <= pins.pull_en[i] | ~pin_in[i];
            end
        end
    end
endmodule : gpsc_board
`default_nettype wire

// ---- verification/gpsc_port_bench.sv ----
// Purpose: Self-checking bench for the eight-pin port
// Assumes: Reads are checked two edges after the strobe is launched
// Notes:   Pin waits of eight cycles cover board, synchroniser and edge stages
`default_nettype none
module gpsc_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clock   = 1'b0;
    logic                 reset   = 1'b1;
    gpsc_pkg::gpsc_bus_t  bus     = '0;
    gpsc_pkg::gpsc_pins_t pins;
    logic [7:0]           rdata, pin_in, lvl, v;
    logic [7:0]           ext_val = 8'h00;
    logic [7:0]           ext_en  = 8'hff;
    logic                 irq;
    logic                 rd_d    = 1'b0;
    logic [31:0]          seed    = 32'h0000_3744;
    logic [7:0]           fall_hit = 8'h2a;
    logic [7:0]           rise_hit = 8'h26;
    logic [7:0]           expq[$];
    int                   error_cnt = 0;
    int                   checks    = 0;
    always #4 clock = ~clock;
    gpsc_port gpsc_port_inst (.clock(clock), .reset(reset), .bus(bus), .rdata(rdata),
        .pin_in(pin_in), .pins(pins), .irq(irq));
    gpsc_board gpsc_board_inst (.clock(clock), .pins(pins), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        expq.push_back(e);
        @(posedge clock);
    endtask : rd
    task automatic wt(input int n);
        bus <= '0;
        repeat (n) @(posedge clock);
    endtask : wt
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : step
    // Oldest expectation meets each read result
    always @(posedge clock) begin
        if (rd_d) begin
            chk("rdata", rdata, expq.pop_front());
        end
        rd_d <= bus.rd;
    end
    initial begin
        repeat (50000) @(posedge clock);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int a = 0; a < 24; a++) rd(5'(a), 8'h00);
        wt(1);
        chk("out_en_n", pins.out_en_n, 8'hff);
        $display("test reset done");
        wr(gpsc_pkg::OFF_DIRECTION, 8'hff);
        wr(5'h0c, 8'hff);
        lvl = 8'h00;
        for (int k = 0; k < 32; k++) begin
            seed = step(seed);
            v = seed[7:0];
            case (k % 4)
                0: lvl = lvl | v;
                1: lvl = lvl & ~v;
                default: lvl = lvl ^ v;
            endcase
            wr(gpsc_pkg::OFF_SET + 5'(k % 4), v);
            rd(gpsc_pkg::OFF_SET + 5'(k % 3), lvl);
        end
        rd(gpsc_pkg::OFF_DIRECTION, 8'hff);
        rd(5'h0c, 8'h00);
        wt(8);
        chk("out_val", pins.out_val, lvl);
        chk("out_en_n", pins.out_en_n, 8'h00);
        rd(gpsc_pkg::OFF_INPUT, lvl);
        $display("test strobes done");
        wr(gpsc_pkg::OFF_PINCFG, 8'h80);
        wt(8);
        chk("out_val", pins.out_val, lvl ^ 8'h01);
        rd(gpsc_pkg::OFF_INPUT, lvl);
        wr(gpsc_pkg::OFF_PINCFG, 8'h00);
        wr(gpsc_pkg::OFF_DIRECTION, 8'h00);
        ext_en <= 8'hfd;
        wr(gpsc_pkg::OFF_PINCFG + 5'h01, 8'h08);
        wt(8);
        chk("pull_en", pins.pull_en, 8'h02);
        rd(gpsc_pkg::OFF_INPUT, 8'h02);
        wr(gpsc_pkg::OFF_DIRECTION, 8'h02);
        wt(2);
        chk("pull_en", pins.pull_en, 8'h00);
        wr(gpsc_pkg::OFF_DIRECTION, 8'h00);
        wr(gpsc_pkg::OFF_PINCFG + 5'h01, 8'h00);
        ext_en <= 8'hff;
        wr(gpsc_pkg::OFF_PORTCTL, 8'hff);
        wt(1);
        chk("slew", {7'h00, pins.slew}, 8'h01);
        rd(gpsc_pkg::OFF_PORTCTL, 8'h01);
        wr(gpsc_pkg::OFF_PORTCTL, 8'h00);
        wt(1);
        chk("slew", {7'h00, pins.slew}, 8'h00);
        $display("test config done");
        // Codes 0..5; edges checked while the pin is driven by the board
        wr(gpsc_pkg::OFF_MASK, 8'hff);
        rd(gpsc_pkg::OFF_MASK, 8'hff);
        // Codes 6 and 7 are reserved and must stay silent
        for (int c = 0; c < 8; c++) begin
            ext_val <= 8'h01;
            wt(8);
            wr(gpsc_pkg::OFF_PINCFG, 8'(c));
            wr(gpsc_pkg::OFF_FLAGS, 8'hff);
            ext_val <= 8'h00;
            wt(8);
            chk("irq", {7'h00, irq}, {7'h00, fall_hit[c]});
            rd(gpsc_pkg::OFF_FLAGS, {7'h00, fall_hit[c]});
            rd(gpsc_pkg::OFF_INPUT, {7'h00, c == 4});
            wr(gpsc_pkg::OFF_FLAGS, 8'h00);
            rd(gpsc_pkg::OFF_FLAGS, {7'h00, fall_hit[c]});
            wr(gpsc_pkg::OFF_FLAGS, 8'hff);
            rd(gpsc_pkg::OFF_FLAGS, {7'h00, c == 5});
            if (c == 5) begin
                wr(gpsc_pkg::OFF_MASK, 8'h00);
                wt(2);
                chk("irq", {7'h00, irq}, 8'h00);
                wr(gpsc_pkg::OFF_MASK, 8'hff);
            end
            ext_val <= 8'h01;
            wt(8);
            rd(gpsc_pkg::OFF_FLAGS, {7'h00, rise_hit[c]});
            wr(gpsc_pkg::OFF_FLAGS, 8'hff);
            rd(gpsc_pkg::OFF_FLAGS, 8'h00);
        end
        $display("test sense done");
        wt(4);
        if (expq.size() != 0) error_cnt++;
        final_report();
    end
endmodule : gpsc_port_bench
`default_nettype wire
